//--- lfs_checker.sv
`timescale 1ns/1ps
`default_nettype none
module lfs_checker #(
    parameter int unsigned N_CH        = 8,
    parameter int unsigned MEAS_PERIOD = 20
) (
    input wire logic            CLK,
    input wire logic            SYS_RST,
    input wire logic            AVS_READ,
    input wire logic            AVS_WRITE,
    input wire logic [31:0]     AVS_READDATA,
    input wire logic            AVS_WAITREQUEST,
    input wire logic [N_CH-1:0] LEAD_OPEN,
    input wire logic [N_CH-1:0] LINE_FAULT,
    input wire logic [N_CH-1:0] VALUE_BLOCKED,
    input wire logic            MEAS_START,
    input wire logic            MEAS_IS_CJC
);
    int unsigned gap_reg;
    logic        seen_reg;
    // the first pulse after reset has no predecessor to measure against
    always_ff @(posedge CLK) begin
        gap_reg  <= (SYS_RST || MEAS_START) ? 0 : gap_reg + 1;
        seen_reg <= SYS_RST ? 1'b0 : (seen_reg || MEAS_START);
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    sequence s_answer;
        !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
    endsequence
    AST_WAIT_ONE: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> s_answer)
        else $error("bus answer not one wait state");
    AST_IDLE_WAIT: assert property (!AVS_READ && !AVS_WRITE |=> AVS_WAITREQUEST)
        else $error("waitrequest low without request");
    AST_RDATA_HOLD: assert property ($changed(AVS_READDATA) |-> AVS_READ && !AVS_WAITREQUEST)
        else $error("read data moved outside an answer");
    AST_MEAS_GAP: assert property (MEAS_START && seen_reg |-> gap_reg == MEAS_PERIOD - 1)
        else $error("measurement start spacing wrong");
    AST_CJC_WITH_START: assert property ($changed(MEAS_IS_CJC) |-> MEAS_START)
        else $error("compensation flag moved without start");
    AST_BLOCK_COVERS: assert property ((LINE_FAULT & ~VALUE_BLOCKED) == '0)
        else $error("fault without blocked value");
    AST_FAULT_NEEDS_PIN: assert property ((LINE_FAULT & ~($past(LEAD_OPEN, 2)
        | $past(LEAD_OPEN, 3) | $past(LEAD_OPEN, 4))) == '0) else $error("fault without open lead");
    AST_RELEASE_CLEAR: assert property ((~VALUE_BLOCKED & $past(VALUE_BLOCKED) & LINE_FAULT) == '0)
        else $error("value released during fault");
endmodule : lfs_checker
bind lfs_top lfs_checker #(.N_CH(N_CH), .MEAS_PERIOD(MEAS_PERIOD)) chk_u (.*);
`default_nettype wire

//--- lfs_pkg.sv
// Behaviour
// - Each channel watches its lead-open input and raises a line fault flag while the break is present.
// - A control bit switches line fault detection on or off, and while off no fault is flagged.
// - After a fault the channel's measured value stays blocked for a settable hold-off delay.
// - With an external cold junction the hold-off setting runs 0 to 250 steps of 160 ms each.
// - With an internal cold junction the hold-off setting runs 0 to 250 steps of 240 ms each.
// - With an internal cold junction a set ratio of thermocouple to compensation measurements drives the measurement schedule.
// - Slot status bits are discrete inputs at 2048 (raw) or 14001 (one-based) plus eight times slot plus bit.
// - Bit 1 of each channel word carries the blocked flag, 0 for OK and 1 during a fault or its hold-off.
// - The low four bits of each 16-bit channel word carry status, left out when scaling is outside 10000 to 50000.
package lfs_pkg;
    localparam int unsigned CLK_KHZ           = 200000;
    localparam int unsigned STEP_EXT_MS       = 160;
    localparam int unsigned STEP_INT_MS       = 240;
    localparam int unsigned STEP_EXT_CYCLES   = STEP_EXT_MS * CLK_KHZ;
    localparam int unsigned STEP_INT_CYCLES   = STEP_INT_MS * CLK_KHZ;
    localparam int unsigned MEAS_PERIOD_US    = 1000;
    localparam int unsigned MEAS_CYCLES       = MEAS_PERIOD_US * CLK_KHZ / 1000;
    localparam logic [7:0]  HOLDOFF_MAX       = 8'hFA;
    localparam logic [15:0] SCALE_MIN         = 16'h2710;
    localparam logic [15:0] SCALE_MAX         = 16'hC350;
    localparam logic [15:0] DI_BASE_RAW       = 16'h0800;
    localparam logic [15:0] DI_BASE_ONE       = 16'h36B1;
    localparam int unsigned FAULT_BIT         = 1;
    localparam int unsigned STATUS_BITS       = 4;
    // register byte offsets
    localparam logic [7:0]  OFS_CTRL          = 8'h00;
    localparam logic [7:0]  OFS_STATUS        = 8'h04;
    localparam logic [7:0]  OFS_DI_ADDR       = 8'h08;
    localparam logic [7:0]  OFS_SCALE         = 8'h0C;
    localparam logic [7:0]  OFS_CHAN0         = 8'h20;
    // control and status register fields
    localparam int unsigned CTRL_LFD_EN       = 0;
    localparam int unsigned CTRL_CJ_INT       = 1;
    localparam int unsigned CTRL_HOLD_LSB     = 8;
    localparam int unsigned CTRL_RATIO_LSB    = 16;
    localparam int unsigned STATUS_BLK_LSB    = 16;
    // reset values
    localparam logic        RST_LFD_EN        = 1'b1;
    localparam logic        RST_CJ_INT        = 1'b0;
    localparam logic [7:0]  RST_HOLDOFF       = 8'h0A;
    localparam logic [7:0]  RST_RATIO         = 8'h01;
    localparam logic [15:0] RST_SCALE         = 16'hC350;
endpackage : lfs_pkg

//--- lfs_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
module lfs_sensor_model (
    input  wire logic        CLK,
    input  wire logic        MEAS_START,
    input  wire logic        MEAS_IS_CJC,
    input  wire logic [7:0]  open_cmd,
    input  wire logic [15:0] value,
    output var  logic [7:0]  LEAD_OPEN,
    output var  logic        SAMPLE_VALID,
    output var  logic [2:0]  SAMPLE_CHAN,
    output var  logic [15:0] SAMPLE_DATA
);
    initial begin
        LEAD_OPEN = 8'h00;
        SAMPLE_VALID = 1'b0;
        SAMPLE_CHAN = 3'h0;
        SAMPLE_DATA = 16'h0000;
    end
    // data toggles between samples so a stale word is never mistaken for a fresh one
    always @(posedge CLK) begin
        LEAD_OPEN    <= open_cmd;
        SAMPLE_VALID <= MEAS_START && !MEAS_IS_CJC;
        SAMPLE_DATA  <= (MEAS_START && !MEAS_IS_CJC) ? value : ~SAMPLE_DATA;
    end
endmodule : lfs_sensor_model
`default_nettype wire

//--- lfs_top.sv
`timescale 1ns/1ps
`default_nettype none
module lfs_top #(
    parameter int unsigned N_CH        = 8,
    parameter int unsigned SLOT        = 0,
    parameter int unsigned STEP_EXT    = lfs_pkg::STEP_EXT_CYCLES,
    parameter int unsigned STEP_INT    = lfs_pkg::STEP_INT_CYCLES,
    parameter int unsigned MEAS_PERIOD = lfs_pkg::MEAS_CYCLES
) (
    input  wire logic              CLK,
    input  wire logic              SYS_RST,
    input  wire logic [7:0]        AVS_ADDRESS,
    input  wire logic              AVS_READ,
    input  wire logic              AVS_WRITE,
    input  wire logic [31:0]       AVS_WRITEDATA,
    input  wire logic [3:0]        AVS_BYTEENABLE,
    output var  logic [31:0]       AVS_READDATA,
    output var  logic              AVS_WAITREQUEST,
    input  wire logic [N_CH-1:0]   LEAD_OPEN,
    input  wire logic              SAMPLE_VALID,
    input  wire logic [2:0]        SAMPLE_CHAN,
    input  wire logic [15:0]       SAMPLE_DATA,
    output var  logic [N_CH-1:0]   LINE_FAULT,
    output var  logic [N_CH-1:0]   VALUE_BLOCKED,
    output var  logic              MEAS_START,
    output var  logic              MEAS_IS_CJC
);
    // configuration
    logic        lfd_en_reg;
    logic        cj_int_reg;
    logic [7:0]  holdoff_reg;
    logic [7:0]  ratio_reg;
    logic [15:0] scale_reg;
    logic [7:0]  holdoff_next;

    // bus slave
    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic        wr_take;
    logic        rd_take;
    logic        sel_ctrl;
    logic        sel_status;
    logic        sel_di;
    logic        sel_scale;
    logic        sel_chan;
    logic [2:0]  chan_idx;
    logic        chan_ok;

    // timing
    logic [31:0] step_cnt_reg;
    logic [31:0] step_len;
    logic        step_tick;
    logic [31:0] meas_cnt_reg;
    logic        meas_tick;
    logic [7:0]  tc_cnt_reg;
    logic        cjc_due;

    // per channel
    logic [N_CH-1:0] sync1_reg;
    logic [N_CH-1:0] sync2_reg;
    logic [N_CH-1:0] fault_now;
    logic [N_CH-1:0] blocked_reg;
    logic [N_CH-1:0] fault_reg;
    logic [15:0]     word_arr [N_CH];
    logic            status_on;
    logic [15:0]     di_raw;
    logic [15:0]     di_one;

    assign wr_take    = AVS_WRITE && !wait_reg;
    assign rd_take    = AVS_READ && wait_reg;
    assign sel_ctrl   = AVS_ADDRESS == lfs_pkg::OFS_CTRL;
    assign sel_status = AVS_ADDRESS == lfs_pkg::OFS_STATUS;
    assign sel_di     = AVS_ADDRESS == lfs_pkg::OFS_DI_ADDR;
    assign sel_scale  = AVS_ADDRESS == lfs_pkg::OFS_SCALE;
    assign chan_idx   = 3'((AVS_ADDRESS - lfs_pkg::OFS_CHAN0) >> 2);
    assign sel_chan   = AVS_ADDRESS >= lfs_pkg::OFS_CHAN0 && AVS_ADDRESS[1:0] == 2'h0;
    assign chan_ok    = sel_chan && 32'(chan_idx) < N_CH
                        && AVS_ADDRESS < 8'(lfs_pkg::OFS_CHAN0 + 8'(4 * N_CH));

    // settings above the documented top step are clamped rather than wrapped
    assign holdoff_next = (AVS_WRITEDATA[lfs_pkg::CTRL_HOLD_LSB +: 8] > lfs_pkg::HOLDOFF_MAX)
                          ? lfs_pkg::HOLDOFF_MAX
                          : AVS_WRITEDATA[lfs_pkg::CTRL_HOLD_LSB +: 8];

    // bit address of this slot's bit 0; the master adds the bit number
    assign di_raw = 16'(lfs_pkg::DI_BASE_RAW + 16'(8 * SLOT));
    assign di_one = 16'(lfs_pkg::DI_BASE_ONE + 16'(8 * SLOT));

    assign status_on = scale_reg >= lfs_pkg::SCALE_MIN
                       && scale_reg <= lfs_pkg::SCALE_MAX;

    always_comb begin
        rdata_next = 32'h0000_0000;
        if (sel_ctrl) begin
            rdata_next[lfs_pkg::CTRL_LFD_EN]         = lfd_en_reg;
            rdata_next[lfs_pkg::CTRL_CJ_INT]         = cj_int_reg;
            rdata_next[lfs_pkg::CTRL_HOLD_LSB +: 8]  = holdoff_reg;
            rdata_next[lfs_pkg::CTRL_RATIO_LSB +: 8] = ratio_reg;
        end else if (sel_status) begin
            rdata_next[N_CH-1:0]                          = fault_reg;
            rdata_next[lfs_pkg::STATUS_BLK_LSB +: N_CH]   = blocked_reg;
        end else if (sel_di) begin
            rdata_next = {di_one, di_raw};
        end else if (sel_scale) begin
            rdata_next[15:0] = scale_reg;
        end else if (chan_ok) begin
            rdata_next[15:0] = word_arr[chan_idx];
        end
    end

    // one wait state: request seen, then answered with waitrequest low
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h0000_0000;
        end else begin
            wait_reg <= !((AVS_READ || AVS_WRITE) && wait_reg);
            if (rd_take) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            lfd_en_reg  <= lfs_pkg::RST_LFD_EN;
            cj_int_reg  <= lfs_pkg::RST_CJ_INT;
            holdoff_reg <= lfs_pkg::RST_HOLDOFF;
            ratio_reg   <= lfs_pkg::RST_RATIO;
            scale_reg   <= lfs_pkg::RST_SCALE;
        end else if (wr_take) begin
            if (sel_ctrl && AVS_BYTEENABLE[0]) begin
                lfd_en_reg <= AVS_WRITEDATA[lfs_pkg::CTRL_LFD_EN];
                cj_int_reg <= AVS_WRITEDATA[lfs_pkg::CTRL_CJ_INT];
            end
            if (sel_ctrl && AVS_BYTEENABLE[1]) begin
                holdoff_reg <= holdoff_next;
            end
            if (sel_ctrl && AVS_BYTEENABLE[2]) begin
                ratio_reg <= AVS_WRITEDATA[lfs_pkg::CTRL_RATIO_LSB +: 8];
            end
            if (sel_scale && AVS_BYTEENABLE[0]) begin
                scale_reg[7:0] <= AVS_WRITEDATA[7:0];
            end
            if (sel_scale && AVS_BYTEENABLE[1]) begin
                scale_reg[15:8] <= AVS_WRITEDATA[15:8];
            end
        end
    end

    // hold-off step length follows the cold junction choice
    assign step_len  = cj_int_reg ? STEP_INT : STEP_EXT;
    assign step_tick = step_cnt_reg >= step_len - 32'd1;
    assign meas_tick = meas_cnt_reg >= MEAS_PERIOD - 32'd1;
    assign cjc_due   = cj_int_reg && tc_cnt_reg >= ratio_reg;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            step_cnt_reg <= 32'h0000_0000;
            meas_cnt_reg <= 32'h0000_0000;
        end else begin
            step_cnt_reg <= step_tick ? 32'h0000_0000 : step_cnt_reg + 32'd1;
            meas_cnt_reg <= meas_tick ? 32'h0000_0000 : meas_cnt_reg + 32'd1;
        end
    end

    // every ratio thermocouple cycles one compensation cycle is slotted in
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            tc_cnt_reg  <= 8'h00;
            MEAS_START  <= 1'b0;
            MEAS_IS_CJC <= 1'b0;
        end else begin
            MEAS_START <= meas_tick;
            if (meas_tick) begin
                MEAS_IS_CJC <= cjc_due;
                tc_cnt_reg  <= cjc_due ? 8'h00 : (tc_cnt_reg == 8'hFF ? 8'hFF : tc_cnt_reg + 8'h01);
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < N_CH; g++) begin : g_ch
            logic [7:0]  hold_cnt_reg;
            logic [15:0] raw_reg;
            logic        hold_left;

            assign fault_now[g] = lfd_en_reg && sync2_reg[g];
            assign hold_left    = hold_cnt_reg != 8'h00;

            always_ff @(posedge CLK) begin
                if (SYS_RST) begin
                    sync1_reg[g] <= 1'b0;
                    sync2_reg[g] <= 1'b0;
                end else begin
                    sync1_reg[g] <= LEAD_OPEN[g];
                    sync2_reg[g] <= sync1_reg[g];
                end
            end

            // a step may be partly gone when counting starts, so the wait
            // is up to one step shorter than the setting times the step
            always_ff @(posedge CLK) begin
                if (SYS_RST) begin
                    hold_cnt_reg   <= 8'h00;
                    blocked_reg[g] <= 1'b0;
                end else if (fault_now[g]) begin
                    hold_cnt_reg   <= holdoff_reg;
                    blocked_reg[g] <= 1'b1;
                end else if (!lfd_en_reg) begin
                    hold_cnt_reg   <= 8'h00;
                    blocked_reg[g] <= 1'b0;
                end else begin
                    if (step_tick && hold_left) begin
                        hold_cnt_reg <= hold_cnt_reg - 8'h01;
                    end
                    blocked_reg[g] <= hold_left;
                end
            end

            always_ff @(posedge CLK) begin
                if (SYS_RST) begin
                    raw_reg <= 16'h0000;
                end else if (SAMPLE_VALID && SAMPLE_CHAN == 3'(g)) begin
                    raw_reg <= SAMPLE_DATA;
                end
            end

            // while blocked the value field reads zero, the status stays
            always_comb begin
                word_arr[g] = blocked_reg[g] ? 16'h0000 : raw_reg;
                if (status_on) begin
                    word_arr[g][lfs_pkg::STATUS_BITS-1:0]  = 4'h0;
                    word_arr[g][lfs_pkg::FAULT_BIT]        = blocked_reg[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            fault_reg     <= '0;
            LINE_FAULT    <= '0;
            VALUE_BLOCKED <= '0;
        end else begin
            fault_reg     <= fault_now;
            LINE_FAULT    <= fault_now;
            // fault_now joins in so the output never trails the fault flag
            VALUE_BLOCKED <= blocked_reg | fault_now;
        end
    end

    assign AVS_READDATA    = rdata_reg;
    assign AVS_WAITREQUEST = wait_reg;
endmodule : lfs_top
`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic        CLK = 1'b0;
    logic        SYS_RST = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdat, r;
    logic        wreq, sv, cjc, mst;
    logic [7:0]  lead, open_cmd = 8'h00;
    logic [2:0]  sch;
    logic [15:0] sdat, sc;
    logic [3:0]  be = 4'hF;
    logic [15:0] val = 16'hABC7;
    logic [7:0]  lf, vb;
    int          n_mismatch = 0;
    int          checked = 0;
    always #2.5 CLK = ~CLK;
    lfs_top #(.N_CH(8), .SLOT(3), .STEP_EXT(16), .STEP_INT(24), .MEAS_PERIOD(20)) dut_u (
        .CLK(CLK), .SYS_RST(SYS_RST), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat), .AVS_WAITREQUEST(wreq),
        .LEAD_OPEN(lead), .SAMPLE_VALID(sv), .SAMPLE_CHAN(sch), .SAMPLE_DATA(sdat),
        .LINE_FAULT(lf), .VALUE_BLOCKED(vb), .MEAS_START(mst), .MEAS_IS_CJC(cjc));
    lfs_sensor_model sens_u (.CLK(CLK), .MEAS_START(mst), .MEAS_IS_CJC(cjc),
        .open_cmd(open_cmd), .value(val), .LEAD_OPEN(lead), .SAMPLE_VALID(sv),
        .SAMPLE_CHAN(sch), .SAMPLE_DATA(sdat));
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
    endtask : cyc
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        do @(posedge CLK); while (wreq !== 1'b0);
        r = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic ochk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : ochk
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        ochk(r, exp);
    endtask : rchk
    task automatic hold_run(input logic [31:0] ctl, input int h, input int c);
        bus(1'b1, 8'h00, ctl);
        open_cmd <= 8'h01;
        cyc(6);
        ochk({24'h0, lf}, 32'h01);
        ochk({24'h0, vb}, 32'h01);
        rchk(8'h04, 32'h0001_0001);
        rchk(8'h20, 32'h0000_0002);
        open_cmd <= 8'h00;
        cyc(h);
        rchk(8'h04, 32'h0001_0000);
        open_cmd <= 8'h01;
        cyc(4);
        open_cmd <= 8'h00;
        cyc(h);
        rchk(8'h04, 32'h0001_0000);
        cyc(c);
        rchk(8'h04, 32'h0);
        ochk({lf, vb}, 16'h0);
        $display("hold-off test done, control %h", ctl);
    endtask : hold_run
    task automatic ratio_run(input logic [7:0] ratio, input int exp);
        int n;
        n = 0;
        bus(1'b1, 8'h00, {8'h00, ratio, 16'h0303});
        cyc(70);
        repeat (6) begin
            do @(posedge CLK); while (mst !== 1'b1);
            if (cjc === 1'b1) n++;
        end
        r = n;
        checked++;
        if (n != exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, n, exp);
        end
        $display("ratio test done, ratio %0d", ratio);
    endtask : ratio_run
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (20000) @(posedge CLK);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        cyc(3);
        SYS_RST <= 1'b0;
        rchk(8'h00, 32'h0001_0A01);
        rchk(8'h0C, 32'h0000_C350);
        rchk(8'h08, 32'h36C9_0818);
        rchk(8'h40, 32'h0);
        $display("reset test done");
        cyc(50);
        for (int i = 0; i < 4; i++) begin
            sc = (i == 0) ? 16'h270F : (i == 1) ? 16'h2710 : (i == 2) ? 16'hC350 : 16'hC351;
            bus(1'b1, 8'h0C, {16'h0, sc});
            rchk(8'h20, (sc >= 16'h2710 && sc <= 16'hC350) ? 32'hABC0 : 32'hABC7);
        end
        be <= 4'h2;
        bus(1'b1, 8'h0C, 32'h0000_0000);
        rchk(8'h0C, 32'h0000_0051);
        be <= 4'hF;
        bus(1'b1, 8'h0C, 32'h0000_C350);
        $display("scaling test done");
        hold_run(32'h0001_0301, 28, 26);
        hold_run(32'h0001_0303, 44, 36);
        bus(1'b1, 8'h00, 32'h0001_0300);
        open_cmd <= 8'h01;
        cyc(50);
        rchk(8'h04, 32'h0);
        rchk(8'h20, 32'h0000_ABC0);
        ochk({lf, vb}, 16'h0);
        open_cmd <= 8'h00;
        $display("disable test done");
        ratio_run(8'h00, 6);
        ratio_run(8'h02, 2);
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
